// ==== common/mdu_pkg.sv ====
// package: constants and carrier types for the multidrop uart extension
// What this block does
// - master transmitter sends 9th bit one for address, zero for data
// - normal multidrop: 9th bit parity error marks address, raises interrupt
// - normal multidrop, receiver disabled: data bytes dropped, not queued
// - normal multidrop, receiver disabled: address byte queued, data-ready raised
// - normal multidrop, receiver enabled: every byte queued
// - normal multidrop, receiver enabled: address raises parity-error interrupt
// - auto address detect needs both control bits 0 and 2
// - auto mode compares every address byte with station match value
// - auto mode, disabled: data and non-matching addresses discarded
// - matching address queued with 9th bit, receiver enabled, data-ready raised
// - auto mode, enabled: non-matching address disables receiver, not queued
// - control bit 4 turns automatic direction control on
// - control bit 3 picks request-to-send or data-terminal-ready pin
// - direction pin low on transmit write, high after last bit
// - automatic direction overrides other pin sources except loopback
// - release delayed by 0 to 255 baud periods after last stop bit
// - control bit 5 inverts direction output polarity
// - baud generator divides bus clock by 16-bit divisor for 16x tick
// - receive shift register assembles character then hands to queue
// - events reach interrupt logic as single-cycle pulses
package mdu_pkg;
  localparam int CTL_NMM = 0;
  localparam int CTL_RXDIS = 1;
  localparam int CTL_AAD = 2;
  localparam int CTL_SEL = 3;
  localparam int CTL_DCTRL = 4;
  localparam int CTL_OINV = 5;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam int DATA_W = 9;
  localparam int QUEUE_DEPTH = 16;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] BITS_LAST = 4'hA;
  localparam logic [15:0] DIV_ONE = 16'h0001;

  typedef struct packed {
    logic [8:0] data;
    logic valid;
  } mdu_char_type;

  typedef struct packed {
    logic rx_ready;
    logic parity_err;
    logic framing_err;
    logic tx_empty;
  } mdu_event_type;
endpackage

// ==== design/mdu_top.sv ====
// multidrop uart: baud tick, tx/rx shifters, address filter, direction control, queue
module mdu_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } mdu_fifo_state_type;
  mdu_fifo_state_type s_q, s_d;
  logic push, pop;
  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop)
      s_d.rd = s_q.rd + 1'b1;
    if (push && !pop)
      s_d.cnt = s_q.cnt + 1'b1;
    else if (pop && !push)
      s_d.cnt = s_q.cnt - 1'b1;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

module mdu_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [mdu_pkg::CTL_W-1:0] multidrop_control,
  input wire logic control_write,
  output logic [mdu_pkg::CTL_W-1:0] multidrop_control_reg,
  input wire logic [7:0] station_address_match,
  input wire logic [7:0] direction_release_delay,
  input wire logic [7:0] divisor_low,
  input wire logic [7:0] divisor_high,
  input wire logic loopback,
  input wire logic rts_manual_n,
  input wire logic dtr_manual_n,
  input wire logic [7:0] tx_data,
  input wire logic tx_is_address,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  output logic rts_n,
  output logic dtr_n,
  output mdu_pkg::mdu_char_type rx_char,
  input wire logic rx_take,
  output logic rx_queue_full,
  output mdu_pkg::mdu_event_type events
);
  import mdu_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_HOLD} mdu_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} mdu_rx_state_type;

  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [15:0] div_cnt;
    logic tick;
    logic [2:0] rx_sync;
    logic rx_line;
    mdu_tx_state_type tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_os;
    logic [3:0] tx_bits;
    logic [7:0] hold_cnt;
    logic [7:0] tx_buf;
    logic tx_buf_addr;
    logic tx_buf_full;
    logic dir_active;
    mdu_rx_state_type rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bits;
    logic [9:0] rx_sh;
    logic [8:0] push_data;
    logic push_valid;
    mdu_event_type ev;
    logic txd;
  } mdu_state_type;

  mdu_state_type s_q, s_d;
  logic q_in_ready;
  logic [15:0] divisor;
  logic aad_mode;

  function automatic logic [10:0] frame_of(input logic [7:0] d, input logic a);
    frame_of = {1'b1, a, d, 1'b0};
  endfunction

  assign divisor = {divisor_high, divisor_low};
  assign aad_mode = s_q.ctl[CTL_NMM] && s_q.ctl[CTL_AAD];
  assign tx_ready = !s_q.tx_buf_full;

  always_comb
  begin
    logic [8:0] ch;
    logic is_addr;
    logic keep;
    s_d = s_q;
    ch = '0;
    is_addr = 1'b0;
    keep = 1'b0;
    s_d.ev = '0;
    // push is a one-cycle offer; a full queue drops it rather than replaying it later
    s_d.push_valid = 1'b0;
    if (control_write)
      s_d.ctl = multidrop_control;
    // baud generator; divisor zero treated as one
    s_d.tick = 1'b0;
    if (s_q.div_cnt + 16'h0001 >= ((divisor == '0) ? DIV_ONE : divisor))
    begin
      s_d.div_cnt = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
    // three-stage input sync; change counts when stages two and three agree
    s_d.rx_sync = {s_q.rx_sync[1:0], serial_in_pin};
    if (s_q.rx_sync[2] == s_q.rx_sync[1])
      s_d.rx_line = s_q.rx_sync[2];
    // transmit holding buffer
    if (tx_valid && !s_q.tx_buf_full)
    begin
      s_d.tx_buf = tx_data;
      s_d.tx_buf_addr = tx_is_address;
      s_d.tx_buf_full = 1'b1;
      s_d.dir_active = 1'b1;
    end
    case (s_q.tx_st)
      TX_IDLE:
      begin
        s_d.txd = 1'b1;
        if (s_q.tx_buf_full)
        begin
          s_d.tx_sh = frame_of(s_q.tx_buf, s_q.tx_buf_addr);
          s_d.tx_buf_full = 1'b0;
          s_d.tx_os = '0;
          s_d.tx_bits = '0;
          s_d.tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT:
      begin
        s_d.txd = s_q.tx_sh[0];
        if (s_q.tick)
        begin
          s_d.tx_os = s_q.tx_os + 4'h1;
          if (s_q.tx_os == OS_LAST)
          begin
            s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
            s_d.tx_bits = s_q.tx_bits + 4'h1;
            if (s_q.tx_bits == BITS_LAST)
            begin
              s_d.txd = 1'b1;
              s_d.hold_cnt = '0;
              s_d.tx_st = TX_HOLD;
            end
          end
        end
      end
      TX_HOLD:
      begin
        // a queued character skips the release so the driver stays on
        if (s_q.tx_buf_full)
          s_d.tx_st = TX_IDLE;
        else if (s_q.hold_cnt == direction_release_delay)
        begin
          s_d.dir_active = s_d.tx_buf_full;
          s_d.ev.tx_empty = 1'b1;
          s_d.tx_st = TX_IDLE;
        end
        else if (s_q.tick)
        begin
          s_d.tx_os = s_q.tx_os + 4'h1;
          if (s_q.tx_os == OS_LAST)
            s_d.hold_cnt = s_q.hold_cnt + 8'h01;
        end
      end
      default:
        s_d.tx_st = TX_IDLE;
    endcase
    // receiver: start bit, 8 data, 9th bit, stop, sampled mid-bit
    case (s_q.rx_st)
      RX_IDLE:
        if (!s_q.rx_line)
        begin
          s_d.rx_os = '0;
          s_d.rx_bits = '0;
          s_d.rx_st = RX_SHIFT;
        end
      RX_SHIFT:
        if (s_q.tick)
        begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == OS_MID)
          begin
            s_d.rx_bits = s_q.rx_bits + 4'h1;
            if (s_q.rx_bits == '0 && s_q.rx_line)
              s_d.rx_st = RX_IDLE;
            else if (s_q.rx_bits == BITS_LAST)
            begin
              s_d.rx_st = RX_IDLE;
              ch = s_q.rx_sh[9:1];
              is_addr = ch[8];
              s_d.ev.framing_err = !s_q.rx_line;
              if (aad_mode)
              begin
                if (is_addr && ch[7:0] == station_address_match)
                begin
                  keep = 1'b1;
                  s_d.ctl[CTL_RXDIS] = 1'b0;
                end
                else if (is_addr)
                  s_d.ctl[CTL_RXDIS] = 1'b1;
                else
                  keep = !s_q.ctl[CTL_RXDIS];
              end
              else if (s_q.ctl[CTL_NMM])
              begin
                keep = is_addr || !s_q.ctl[CTL_RXDIS];
                s_d.ev.parity_err = is_addr;
              end
              else
                keep = 1'b1;
              if (keep)
              begin
                s_d.push_data = ch;
                s_d.push_valid = 1'b1;
                s_d.ev.rx_ready = 1'b1;
              end
            end
            else
              s_d.rx_sh = {s_q.rx_line, s_q.rx_sh[9:1]};
          end
        end
      default:
        s_d.rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.ctl <= CTL_RESET;
      s_q.rx_sync <= 3'h7;
      s_q.rx_line <= 1'b1;
      s_q.txd <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // overflowing characters are lost while the queue is full; the shifter never stalls
  mdu_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_queue (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(s_q.push_data),
    .in_valid(s_q.push_valid),
    .in_ready(q_in_ready),
    .out_data(rx_char.data),
    .out_valid(rx_char.valid),
    .out_ready(rx_take)
  );

  always_comb
  begin
    logic dir_level;
    dir_level = s_q.dir_active ~^ s_q.ctl[CTL_OINV];
    rts_n = rts_manual_n;
    dtr_n = dtr_manual_n;
    if (s_q.ctl[CTL_DCTRL] && !loopback)
    begin
      if (s_q.ctl[CTL_SEL])
        dtr_n = dir_level;
      else
        rts_n = dir_level;
    end
  end

  assign serial_out_pin = loopback ? 1'b1 : s_q.txd;
  assign multidrop_control_reg = s_q.ctl;
  assign rx_queue_full = !q_in_ready;
  assign events = s_q.ev;
endmodule

// ==== test/mdu_checker.sv ====
// concurrent checks on the multidrop uart top-level ports
module mdu_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic control_write,
  input wire logic [mdu_pkg::CTL_W-1:0] multidrop_control_reg,
  input wire logic loopback,
  input wire logic rts_manual_n,
  input wire logic dtr_manual_n,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire mdu_pkg::mdu_char_type rx_char,
  input wire logic rx_queue_full,
  input wire mdu_pkg::mdu_event_type events
);
  import mdu_pkg::*;
  wire dc = multidrop_control_reg[CTL_DCTRL];
  wire sel = multidrop_control_reg[CTL_SEL];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_rx_pulse: assert property (events.rx_ready |=> !events.rx_ready)
    else $error("rx_ready longer than one cycle");
  a_txe_pulse: assert property (events.tx_empty |=> !events.tx_empty)
    else $error("tx_empty longer than one cycle");
  a_loop_wins: assert property (loopback |-> rts_n == rts_manual_n && dtr_n == dtr_manual_n)
    else $error("loopback did not pass manual pins");
  a_dir_off: assert property (!dc |-> rts_n == rts_manual_n && dtr_n == dtr_manual_n)
    else $error("direction driven while disabled");
  a_pin_select: assert property (dc && !loopback |-> (sel ? rts_n == rts_manual_n : dtr_n == dtr_manual_n))
    else $error("unselected pin overridden");
  a_dir_assert: assert property (tx_valid && tx_ready && dc && !loopback && !control_write
    |=> (sel ? dtr_n : rts_n) == multidrop_control_reg[CTL_OINV])
    else $error("direction not asserted after write");
  // hardware may only touch the disable bit, and only in auto address mode
  a_hw_rxdis: assert property (!$past(control_write) && multidrop_control_reg != $past(multidrop_control_reg)
    |-> (multidrop_control_reg ^ $past(multidrop_control_reg)) == 6'h02 && multidrop_control_reg[0]
    && multidrop_control_reg[2])
    else $error("control changed by hardware outside auto mode");
  a_full_valid: assert property (rx_queue_full |-> rx_char.valid)
    else $error("full queue shows no char");
endmodule
bind mdu_top mdu_checker u_mdu_checker (.core_clk, .rst, .control_write, .multidrop_control_reg,
  .loopback, .rts_manual_n, .dtr_manual_n, .tx_valid, .tx_ready, .rts_n, .dtr_n, .rx_char,
  .rx_queue_full, .events);

// ==== test/mdu_node.sv ====
// remote bus node that sends 9-bit characters on the shared line
module mdu_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic core_clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  // line idles at mark between frames, as the transceiver leaves it
  initial line = 1'b1;
  task automatic send(input logic [8:0] ch);
    logic [10:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line = fr[i];
      repeat (BIT_CYC) @(posedge core_clk);
      #1;
    end
  endtask
endmodule

// ==== test/test_mdu_top.sv ====
// self-checking bench for the multidrop uart top
module test_mdu_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mdu_pkg::*;
  typedef struct packed {
    logic [5:0] ctl;
    logic [8:0] ch;
    logic q;
    logic [5:0] after;
  } mdu_row_type;
  logic core_clk, rst, control_write, loopback, rts_manual_n, dtr_manual_n;
  logic tx_is_address, tx_valid, rx_take, ev_clr, tx_ready, serial_out_pin, serial_in_pin;
  logic rts_n, dtr_n, rx_queue_full;
  logic [5:0] multidrop_control, multidrop_control_reg;
  logic [7:0] station_address_match, direction_release_delay, tx_data, div_lo;
  mdu_char_type rx_char;
  mdu_event_type events;
  logic [3:0] seen;
  int fails = 0;
  int checked = 0;
  mdu_row_type rows [10] = '{
    '{6'h03, 9'h055, 1'b0, 6'h03},
    '{6'h03, 9'h1A5, 1'b1, 6'h03},
    '{6'h01, 9'h03C, 1'b1, 6'h01},
    '{6'h01, 9'h1C3, 1'b1, 6'h01},
    '{6'h07, 9'h05A, 1'b0, 6'h07},
    '{6'h07, 9'h133, 1'b0, 6'h07},
    '{6'h07, 9'h15A, 1'b1, 6'h05},
    '{6'h05, 9'h011, 1'b1, 6'h05},
    '{6'h05, 9'h177, 1'b0, 6'h07},
    '{6'h06, 9'h1EE, 1'b1, 6'h06}
  };
  mdu_top u_mdu_top (.core_clk, .rst, .multidrop_control, .control_write,
    .multidrop_control_reg, .station_address_match, .direction_release_delay,
    .divisor_low(div_lo), .divisor_high(8'h00), .loopback, .rts_manual_n, .dtr_manual_n,
    .tx_data, .tx_is_address, .tx_valid, .tx_ready, .serial_out_pin, .serial_in_pin,
    .rts_n, .dtr_n, .rx_char, .rx_take, .rx_queue_full, .events);
  mdu_node u_mdu_node (.core_clk, .line(serial_in_pin));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) seen <= ev_clr ? 4'h0 : seen | events;
  task automatic conclude();
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic set_ctl(input logic [5:0] v);
    multidrop_control = v;
    control_write = 1'b1;
    tick(1);
    control_write = 1'b0;
    ev_clr = 1'b1;
    tick(1);
    ev_clr = 1'b0;
  endtask
  task automatic pop();
    rx_take = 1'b1;
    tick(1);
    rx_take = 1'b0;
    tick(1);
  endtask
  // bounded wait while a line holds a level; running out ends the run
  task automatic hold(input logic v, input int lim, output int n);
    n = 0;
    while (((multidrop_control_reg[3] ? dtr_n : rts_n) === v) && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n == lim)
    begin
      fails++;
      conclude();
    end
  endtask
  task automatic tx_run(input logic [5:0] c, input logic [8:0] ch, input logic [7:0] d);
    logic [8:0] got;
    int n;
    direction_release_delay = d;
    set_ctl(c);
    chk("tx_ready", tx_ready, 1'b1);
    {tx_is_address, tx_data} = ch;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    chk("tx_ready busy", tx_ready, 1'b0);
    tick(1);
    chk("dir on", c[3] ? dtr_n : rts_n, c[5]);
    n = 0;
    while (serial_out_pin === 1'b1 && n < 8)
    begin
      tick(1);
      n++;
    end
    tick(8 * div_lo);
    for (int k = 0; k < 9; k++)
    begin
      tick(16 * div_lo);
      got[k] = serial_out_pin;
    end
    chk("frame", got, ch);
    tick(16 * div_lo);
    chk("stop", serial_out_pin, 1'b1);
    tick(4);
    hold(c[5], 16 * d * div_lo + 20, n);
    chk("release", n >= 16 * d * div_lo + 2, 1'b1);
    tick(4);
    chk("tx_empty", seen[0], 1'b1);
  endtask
  initial
  begin
    rst = 1'b1;
    {control_write, loopback, tx_is_address, tx_valid, rx_take, ev_clr} = 6'h00;
    {rts_manual_n, dtr_manual_n} = 2'h1;
    multidrop_control = 6'h00;
    station_address_match = 8'h5A;
    direction_release_delay = 8'h00;
    tx_data = 8'h00;
    div_lo = 8'h01;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk("ctl reset", multidrop_control_reg, 6'h00);
    chk("rx reset", rx_char.valid, 1'b0);
    chk("txd reset", serial_out_pin, 1'b1);
    set_ctl(6'h10);
    chk("rts idle", rts_n, 1'b1);
    loopback = 1'b1;
    tick(1);
    chk("rts loop", rts_n, 1'b0);
    loopback = 1'b0;
    foreach (rows[i])
    begin
      set_ctl(rows[i].ctl);
      u_mdu_node.send(rows[i].ch);
      tick(40);
      chk("queued", rx_char.valid, rows[i].q);
      chk("rx_ready", seen[3], rows[i].q);
      chk("framing", seen[1], 1'b0);
      if (rows[i].q)
        chk("char", rx_char.data, rows[i].ch);
      if (!rows[i].ctl[2])
        chk("parity_err", seen[2], rows[i].ch[8]);
      chk("ctl", multidrop_control_reg, rows[i].after);
      if (rx_char.valid === 1'b1)
        pop();
    end
    tx_run(6'h10, 9'h1A5, 8'h02);
    tx_run(6'h38, 9'h03C, 8'h00);
    div_lo = 8'h02;
    tx_run(6'h10, 9'h0C3, 8'h01);
    div_lo = 8'h01;
    set_ctl(6'h00);
    for (int i = 0; i < 17; i++)
      u_mdu_node.send({1'b0, 8'(i)});
    tick(40);
    chk("full", rx_queue_full, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      chk("fifo char", rx_char.data, {1'b0, 8'(i)});
      pop();
    end
    chk("empty", rx_char.valid, 1'b0);
    conclude();
  end
endmodule
